//--- hw/ifl_cfg.svh
`ifndef IFL_CFG_SVH
`define IFL_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define IFL_IDX_T0CTL 8'h05
`define IFL_IDX_CPU_STATUS_CONTROL 8'h06
`define IFL_IDX_CORE_IRQ_STATUS_REG 8'h07
`define IFL_IDX_PIR 8'h16
`define IFL_IDX_PIE 8'h17
`define IFL_IDX_TMRCFG 8'h20

// Bit positions in the peripheral flag and enable registers.
`define IFL_P_PORT 7
`define IFL_P_T3 6
`define IFL_P_T2 5
`define IFL_P_T1 4
`define IFL_P_CAP2 3
`define IFL_P_CAP1 2
`define IFL_P_TX 1
`define IFL_P_RX 0

// Bit positions in the core interrupt status register.
`define IFL_I_COMBINED_PERIPHERAL_FLAG 7
`define IFL_I_PINF 6
`define IFL_I_T0F 5
`define IFL_I_EXTF 4
`define IFL_I_PEIE 3
`define IFL_I_PINE 2
`define IFL_I_T0E 1
`define IFL_I_EXTE 0

// Bit positions in the cpu status and timer0 control registers.
`define IFL_C_STACK 5
`define IFL_C_GLOBAL_IRQ_DISABLE 4
`define IFL_C_WDT 3
`define IFL_C_PD 2
`define IFL_T_EXTEDGE 7
`define IFL_T_PINEDGE 6

// Bit positions in the timer configuration register.
`define IFL_M_CAP1SEL 0
`define IFL_M_WIDE 1

// Reset values and the 16-bit timer wrap value.
`define IFL_RST_PIR 8'h02
`define IFL_RST_ZERO 8'h00
`define IFL_WRAP16 16'hFFFF
`define IFL_ZERO16 16'h0000
`define IFL_ZERO8 8'h00

// Bus response codes.
`define IFL_RESP_OKAY 2'h0
`define IFL_RESP_SLVERR 2'h2

`endif

//--- hw/ifl_pkg.sv
package ifl_pkg;

   // Register selected by a bus address.
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_T0CTL,
      SEL_CPU_STATUS_CONTROL,
      SEL_CORE_IRQ_STATUS_REG,
      SEL_PIR,
      SEL_PIE,
      SEL_TMRCFG
   } ifl_sel_t;

   typedef logic [7:0] ifl_byte_t;

endpackage

//--- hw/ifl_top.sv
// Decided for this implementation: the AXI4-Lite register port.
`include "ifl_cfg.svh"

module ifl_top #(
   parameter int PORT_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [PORT_W-1:0] port_b_pins,
   input wire logic port_b_read,
   input wire logic [15:0] timer3_count,
   input wire logic [15:0] timer3_period_pair,
   input wire logic [7:0] timer2_count,
   input wire logic [7:0] timer2_period,
   input wire logic [7:0] timer1_count,
   input wire logic [7:0] timer1_period,
   input wire logic [15:0] timer0_count,
   input wire logic capture1_pin_event,
   input wire logic capture2_pin_event,
   input wire logic tx_buffer_empty,
   input wire logic rx_buffer_full,
   input wire logic ext_irq_pin,
   input wire logic timer0_clock_pin,
   input wire logic wdt_expired_flag,
   input wire logic powerdown_flag,
   input wire logic stack_room_flag,
   input wire logic core_sleeping,
   output logic core_irq_req,
   output logic wake_req
);
   import ifl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and write paths.
   function automatic ifl_sel_t decode(input logic [31:0] addr);
      ifl_sel_t s;
      s = SEL_NONE;
      if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0)
      begin
         case (addr[9:2])
            `IFL_IDX_T0CTL: s = SEL_T0CTL;
            `IFL_IDX_CPU_STATUS_CONTROL: s = SEL_CPU_STATUS_CONTROL;
            `IFL_IDX_CORE_IRQ_STATUS_REG: s = SEL_CORE_IRQ_STATUS_REG;
            `IFL_IDX_PIR: s = SEL_PIR;
            `IFL_IDX_PIE: s = SEL_PIE;
            `IFL_IDX_TMRCFG: s = SEL_TMRCFG;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   ifl_byte_t pflag_q;
   ifl_byte_t peripheral_enable_reg;
   ifl_byte_t istat_q;
   ifl_byte_t timer0_control_reg;
   logic [1:0] tmrcfg_q;
   logic global_irq_disable;
   logic aw_got_q;
   logic w_got_q;
   logic [31:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [PORT_W-1:0] port_latch_q;
   logic [15:0] t3_prev_q;
   logic [15:0] t0_prev_q;
   logic [7:0] t2_prev_q;
   logic [7:0] t1_prev_q;
   logic ext_prev_q;
   logic pin_prev_q;

   logic have_aw;
   logic have_w;
   logic wr_fire;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   ifl_sel_t wr_sel;
   logic wr_lane;
   ifl_byte_t pset;
   ifl_byte_t peripheral_flag_reg;
   ifl_byte_t cpu_status_control;
   ifl_byte_t core_irq_status_reg;
   logic [15:0] t3_match;
   logic [15:0] t1_pair_now;
   logic [15:0] t1_pair_prev;
   logic ext_edge;
   logic pin_edge;
   logic t0_wrap;
   logic combined_peripheral_flag;
   ifl_byte_t istat_set;

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order.
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready = !w_got_q && !s_axi_bvalid;
   assign have_aw = aw_got_q || s_axi_awvalid;
   assign have_w = w_got_q || s_axi_wvalid;
   assign wr_fire = have_aw && have_w && !s_axi_bvalid;
   assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
   assign wr_data = w_got_q ? wdata_q : s_axi_wdata;
   assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb;
   assign wr_sel = decode(wr_addr);
   assign wr_lane = wr_fire && wr_strb[0];

   // Hold whichever half of a write arrives first.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 32'h00000000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready && !wr_fire)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_got_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready && !wr_fire)
         begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_got_q <= 1'b0;
      end
   end

   // Write response, one cycle after both halves are present.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IFL_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wr_sel == SEL_NONE) ? `IFL_RESP_SLVERR : `IFL_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one read at a time, answered one cycle after acceptance.
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `IFL_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `IFL_RESP_OKAY;
         case (decode(s_axi_araddr))
            SEL_T0CTL: s_axi_rdata <= {24'h000000, timer0_control_reg};
            SEL_CPU_STATUS_CONTROL: s_axi_rdata <= {24'h000000, cpu_status_control};
            SEL_CORE_IRQ_STATUS_REG: s_axi_rdata <= {24'h000000, core_irq_status_reg};
            SEL_PIR: s_axi_rdata <= {24'h000000, peripheral_flag_reg};
            SEL_PIE: s_axi_rdata <= {24'h000000, peripheral_enable_reg};
            SEL_TMRCFG: s_axi_rdata <= {30'h0, tmrcfg_q};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `IFL_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Previous samples of counts and pins, for wrap and edge detection.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         t3_prev_q <= `IFL_ZERO16;
         t0_prev_q <= `IFL_ZERO16;
         t2_prev_q <= `IFL_ZERO8;
         t1_prev_q <= `IFL_ZERO8;
         ext_prev_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else
      begin
         t3_prev_q <= timer3_count;
         t0_prev_q <= timer0_count;
         t2_prev_q <= timer2_count;
         t1_prev_q <= timer1_count;
         ext_prev_q <= ext_irq_pin;
         pin_prev_q <= timer0_clock_pin;
      end
   end

   // Port latch is refreshed when the core reads the port, ending a mismatch.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port_latch_q <= '0;
      else if (port_b_read)
         port_latch_q <= port_b_pins;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral set conditions; a wrap is a step from the match value to zero.
   assign t3_match = tmrcfg_q[`IFL_M_CAP1SEL] ? `IFL_WRAP16 : timer3_period_pair;
   assign t1_pair_now = {timer1_count, timer2_count};
   assign t1_pair_prev = {t1_prev_q, t2_prev_q};

   always_comb
   begin
      pset = `IFL_RST_ZERO;
      pset[`IFL_P_PORT] = (port_b_pins != port_latch_q);
      pset[`IFL_P_T3] = (t3_prev_q == t3_match) && (timer3_count == `IFL_ZERO16)
         && (t3_prev_q != timer3_count);
      pset[`IFL_P_T2] = (t2_prev_q == timer2_period) && (timer2_count == `IFL_ZERO8)
         && (t2_prev_q != timer2_count);
      if (tmrcfg_q[`IFL_M_WIDE])
         pset[`IFL_P_T1] = (t1_pair_prev == {timer1_period, timer2_period})
            && (t1_pair_now == `IFL_ZERO16) && (t1_pair_prev != t1_pair_now);
      else
         pset[`IFL_P_T1] = (t1_prev_q == timer1_period) && (timer1_count == `IFL_ZERO8)
            && (t1_prev_q != timer1_count);
      pset[`IFL_P_CAP2] = capture2_pin_event;
      pset[`IFL_P_CAP1] = capture1_pin_event;
   end

   // Writable peripheral flags; a set in the same cycle as a clear wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pflag_q <= `IFL_RST_ZERO;
      else if (wr_lane && wr_sel == SEL_PIR)
         pflag_q <= wr_data[7:0] | pset;
      else
         pflag_q <= pflag_q | pset;
   end

   // Serial flags mirror the buffer state and ignore writes.
   always_comb
   begin
      peripheral_flag_reg = pflag_q;
      peripheral_flag_reg[`IFL_P_TX] = tx_buffer_empty;
      peripheral_flag_reg[`IFL_P_RX] = rx_buffer_full;
   end

   // Peripheral enables, timer configuration and timer0 control.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         peripheral_enable_reg <= `IFL_RST_ZERO;
         timer0_control_reg <= `IFL_RST_ZERO;
         tmrcfg_q <= 2'h0;
      end
      else if (wr_lane)
      begin
         if (wr_sel == SEL_PIE)
            peripheral_enable_reg <= wr_data[7:0];
         if (wr_sel == SEL_T0CTL)
            timer0_control_reg <= wr_data[7:0];
         if (wr_sel == SEL_TMRCFG)
            tmrcfg_q <= wr_data[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core interrupt status: pin edges, timer0 wrap and combined flag.
   assign ext_edge = timer0_control_reg[`IFL_T_EXTEDGE] ? (ext_irq_pin && !ext_prev_q)
      : (!ext_irq_pin && ext_prev_q);
   assign pin_edge = timer0_control_reg[`IFL_T_PINEDGE] ? (timer0_clock_pin && !pin_prev_q)
      : (!timer0_clock_pin && pin_prev_q);
   assign t0_wrap = (t0_prev_q == `IFL_WRAP16) && (timer0_count == `IFL_ZERO16);
   assign combined_peripheral_flag = |(peripheral_flag_reg & peripheral_enable_reg);

   always_comb
   begin
      istat_set = `IFL_RST_ZERO;
      istat_set[`IFL_I_EXTF] = ext_edge;
      istat_set[`IFL_I_T0F] = t0_wrap;
      istat_set[`IFL_I_PINF] = pin_edge;
   end

   // Flags and enables; the combined flag bit is not stored.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         istat_q <= `IFL_RST_ZERO;
      else if (wr_lane && wr_sel == SEL_CORE_IRQ_STATUS_REG)
         istat_q <= (wr_data[7:0] | istat_set) & 8'h7F;
      else
         istat_q <= istat_q | istat_set;
   end

   always_comb
   begin
      core_irq_status_reg = istat_q;
      core_irq_status_reg[`IFL_I_COMBINED_PERIPHERAL_FLAG] = combined_peripheral_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU status: only the global disable is writable; it resets set.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         global_irq_disable <= 1'b1;
      else if (wr_lane && wr_sel == SEL_CPU_STATUS_CONTROL)
         global_irq_disable <= wr_data[`IFL_C_GLOBAL_IRQ_DISABLE];
   end

   always_comb
   begin
      cpu_status_control = `IFL_RST_ZERO;
      cpu_status_control[`IFL_C_STACK] = stack_room_flag;
      cpu_status_control[`IFL_C_GLOBAL_IRQ_DISABLE] = global_irq_disable;
      cpu_status_control[`IFL_C_WDT] = wdt_expired_flag;
      cpu_status_control[`IFL_C_PD] = powerdown_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt request to the core and wake from sleep.
   assign core_irq_req = !global_irq_disable && (
      (istat_q[`IFL_I_EXTF] && istat_q[`IFL_I_EXTE])
      || (istat_q[`IFL_I_T0F] && istat_q[`IFL_I_T0E])
      || (istat_q[`IFL_I_PINF] && istat_q[`IFL_I_PINE])
      || (combined_peripheral_flag && istat_q[`IFL_I_PEIE]));
   assign wake_req = core_sleeping && (
      (istat_q[`IFL_I_EXTF] && istat_q[`IFL_I_EXTE])
      || (istat_q[`IFL_I_PINF] && istat_q[`IFL_I_PINE]));

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   chk_port_mismatch: assert property (@(posedge aclk) disable iff (!aresetn)
      (port_b_pins != port_latch_q) |=> pflag_q[`IFL_P_PORT])
      else $error("Port mismatch did not set the port change flag.");

   chk_t3_overflow: assert property (@(posedge aclk) disable iff (!aresetn)
      (tmrcfg_q[`IFL_M_CAP1SEL] && timer3_count == `IFL_ZERO16
         && $past(timer3_count) == `IFL_WRAP16 && $past(aresetn)) |=> pflag_q[`IFL_P_T3])
      else $error("Timer3 overflow did not set its flag.");

   chk_t2_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer2_count == `IFL_ZERO8 && $past(timer2_count) == timer2_period
         && $past(timer2_count) != `IFL_ZERO8 && $past(aresetn)) |=> pflag_q[`IFL_P_T2])
      else $error("Timer2 wrap did not set its flag.");

   chk_cap2_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      capture2_pin_event |=> pflag_q[`IFL_P_CAP2])
      else $error("Second capture event did not set its flag.");

   chk_cap1_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      capture1_pin_event |=> pflag_q[`IFL_P_CAP1])
      else $error("First capture event did not set its flag.");

   chk_serial_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && decode(s_axi_araddr) == SEL_PIR)
      |=> s_axi_rdata[1:0] == $past({tx_buffer_empty, rx_buffer_full}))
      else $error("Serial flags read back wrong.");

   chk_ext_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (timer0_control_reg[`IFL_T_EXTEDGE] && ext_irq_pin && !ext_prev_q) |=> istat_q[`IFL_I_EXTF])
      else $error("Rising external edge did not set its flag.");

   chk_pin_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      (!timer0_control_reg[`IFL_T_PINEDGE] && !timer0_clock_pin && pin_prev_q)
      |=> istat_q[`IFL_I_PINF])
      else $error("Falling timer0 pin edge did not set its flag.");

   chk_t0_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      (t0_prev_q == `IFL_WRAP16 && timer0_count == `IFL_ZERO16) |=> istat_q[`IFL_I_T0F])
      else $error("Timer0 wrap did not set its flag.");

   chk_global_mask: assert property (@(posedge aclk) disable iff (!aresetn)
      global_irq_disable |-> !core_irq_req)
      else $error("Interrupt requested while globally disabled.");

   chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_lane && wr_sel == SEL_PIR && capture1_pin_event) |=> pflag_q[`IFL_P_CAP1])
      else $error("Flag clear lost a simultaneous event.");

   chk_wake_ext: assert property (@(posedge aclk) disable iff (!aresetn)
      (core_sleeping && istat_q[`IFL_I_EXTF] && istat_q[`IFL_I_EXTE]) |-> wake_req)
      else $error("Enabled external interrupt did not wake the core.");

endmodule // ifl_top

//--- testbench/ifl_core_model.sv
////////////////////////////////////////////////////////////////////////////////
// Behavioural processor core that sleeps, wakes and reads the port.
module ifl_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wake_req,
   input wire logic sleep_cmd,
   input wire logic read_cmd,
   output logic core_sleeping,
   output logic port_b_read
);
   timeunit 1ns;
   timeprecision 1ps;

   // The core dozes on command and leaves sleep as soon as a wake is asked.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         core_sleeping <= 1'b0;
      else if (wake_req)
         core_sleeping <= 1'b0;
      else if (sleep_cmd)
         core_sleeping <= 1'b1;
   end

   // A software read of the port reloads the latch and ends a mismatch.
   always_ff @(posedge aclk)
   begin
      port_b_read <= aresetn && read_cmd;
   end
endmodule // ifl_core_model

//--- testbench/test_interrupt_flag_logic.sv
`include "ifl_cfg.svh"

module test_interrupt_flag_logic;
   timeunit 1ns;
   timeprecision 1ps;
   import ifl_pkg::*;

   localparam logic [7:0] R_T0 = `IFL_IDX_T0CTL;
   localparam logic [7:0] R_CPU = `IFL_IDX_CPU_STATUS_CONTROL;
   localparam logic [7:0] R_CORE = `IFL_IDX_CORE_IRQ_STATUS_REG;
   localparam logic [7:0] R_FLAG = `IFL_IDX_PIR;
   localparam logic [7:0] R_EN = `IFL_IDX_PIE;
   localparam logic [7:0] R_CFG = `IFL_IDX_TMRCFG;

   logic aclk = 1'b0;
   logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [7:0] port_b_pins, timer2_count, timer2_period, timer1_count, timer1_period;
   logic [15:0] timer3_count, timer3_period_pair, timer0_count;
   logic port_b_read, capture1_pin_event, capture2_pin_event, tx_buffer_empty, rx_buffer_full;
   logic ext_irq_pin, timer0_clock_pin, wdt_expired_flag, powerdown_flag, stack_room_flag;
   logic core_sleeping, core_irq_req, wake_req, sleep_cmd, read_cmd;
   int mismatches, check_count, cycles;

   ifl_top #(.PORT_W(8)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_b_pins, .port_b_read, .timer3_count,
      .timer3_period_pair, .timer2_count, .timer2_period, .timer1_count, .timer1_period,
      .timer0_count, .capture1_pin_event, .capture2_pin_event, .tx_buffer_empty,
      .rx_buffer_full, .ext_irq_pin, .timer0_clock_pin, .wdt_expired_flag, .powerdown_flag,
      .stack_room_flag, .core_sleeping, .core_irq_req, .wake_req);

   ifl_core_model core_model (.aclk, .aresetn, .wake_req, .sleep_cmd, .read_cmd,
      .core_sleeping, .port_b_read);

   ////////////////////////////////////////////////////////////////////////////
   // The clock toggles every half period of 4 ns.
   always #4 aclk = !aclk;

   // A hung run is cut short and reported as a failure.
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles >= 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Writes one register; the handshakes are judged on settled values before each edge.
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b_t)
      begin
         @(negedge aclk);
         aw_t = s_axi_awvalid && (s_axi_awready === 1'b1);
         w_t = s_axi_wvalid && (s_axi_wready === 1'b1);
         b_t = (s_axi_bvalid === 1'b1);
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_t)
            s_axi_awvalid <= 1'b0;
         if (w_t)
            s_axi_wvalid <= 1'b0;
         if (b_t)
            s_axi_bready <= 1'b0;
      end
   endtask

   // Reads one register and compares its data and response.
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er = 2'h0);
      logic ar_t, r_t;
      r_t = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_t)
      begin
         @(negedge aclk);
         ar_t = s_axi_arvalid && (s_axi_arready === 1'b1);
         r_t = (s_axi_rvalid === 1'b1);
         if (r_t)
         begin
            check(s_axi_rdata, {24'h0, exp});
            check({30'h0, s_axi_rresp}, {30'h0, er});
         end
         @(posedge aclk);
         if (ar_t)
            s_axi_arvalid <= 1'b0;
         if (r_t)
            s_axi_rready <= 1'b0;
      end
   endtask

   // Sends a one-cycle capture event on the chosen input.
   task automatic pulse_cap(input logic second);
      @(posedge aclk);
      if (second)
         capture2_pin_event <= 1'b1;
      else
         capture1_pin_event <= 1'b1;
      @(posedge aclk);
      capture1_pin_event <= 1'b0;
      capture2_pin_event <= 1'b0;
   endtask

   // Steps one timer through two values, then lets the flag settle.
   task automatic tmr(input int sel, input logic [15:0] a, input logic [15:0] b);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge aclk);
         case (sel)
            0: timer0_count <= i ? b : a;
            1: timer1_count <= i ? b[7:0] : a[7:0];
            2: timer2_count <= i ? b[7:0] : a[7:0];
            3: timer3_count <= i ? b : a;
            default: {timer1_count, timer2_count} <= i ? b : a;
         endcase
      end
      repeat (2) @(posedge aclk);
   endtask

   // Moves one interrupt pin to a level and waits for it to be seen.
   task automatic pin(input logic src, input logic lvl);
      @(posedge aclk);
      if (src)
         timer0_clock_pin <= lvl;
      else
         ext_irq_pin <= lvl;
      repeat (3) @(posedge aclk);
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence of register and event scenarios.
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, port_b_pins, timer0_count} = '0;
      {timer1_count, timer2_count, timer3_count, capture1_pin_event, capture2_pin_event} = '0;
      {rx_buffer_full, ext_irq_pin, timer0_clock_pin, powerdown_flag, sleep_cmd} = '0;
      {read_cmd, mismatches, check_count, cycles} = '0;
      {tx_buffer_empty, wdt_expired_flag, stack_room_flag} = 3'b111;
      s_axi_wstrb = 4'hF;
      timer1_period = 8'h03;
      timer2_period = 8'h05;
      timer3_period_pair = 16'h1234;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      read_cmd <= 1'b1;
      @(posedge aclk);
      read_cmd <= 1'b0;
      rd(R_FLAG, 8'h02);
      rd(R_EN, 8'h00);
      rd(R_CORE, 8'h00);
      rd(R_CPU, 8'h38);
      rd(8'h3F, 8'h00, 2'h2);
      wr(8'h3F, 8'hFF);
      check({30'h0, resp}, 32'h2);
      // Status bits keep following device logic whatever is written.
      wr(R_CPU, 8'h0C);
      rd(R_CPU, 8'h28);
      powerdown_flag <= 1'b1;
      rd(R_CPU, 8'h2C);
      // Serial flags mirror the buffers and ignore writes.
      tx_buffer_empty <= 1'b0;
      rx_buffer_full <= 1'b1;
      wr(R_FLAG, 8'hFF);
      rd(R_FLAG, 8'hFD);
      wr(R_FLAG, 8'h00);
      rd(R_FLAG, 8'h01);
      tx_buffer_empty <= 1'b1;
      rx_buffer_full <= 1'b0;
      pulse_cap(0);
      rd(R_FLAG, 8'h06);
      pulse_cap(1);
      rd(R_FLAG, 8'h0E);
      wr(R_FLAG, 8'h00);
      // Timer wraps, including wraps that miss the period.
      tmr(2, 16'h0004, 16'h0000);
      rd(R_FLAG, 8'h02);
      tmr(2, 16'h0005, 16'h0000);
      rd(R_FLAG, 8'h22);
      wr(R_FLAG, 8'h00);
      tmr(1, 16'h0003, 16'h0000);
      rd(R_FLAG, 8'h12);
      wr(R_FLAG, 8'h00);
      wr(R_CFG, 8'h02);
      tmr(1, 16'h0003, 16'h0000);
      rd(R_FLAG, 8'h02);
      tmr(4, 16'h0305, 16'h0000);
      rd(R_FLAG, 8'h32);
      wr(R_FLAG, 8'h00);
      wr(R_CFG, 8'h00);
      tmr(3, 16'h1234, 16'h0000);
      rd(R_FLAG, 8'h42);
      wr(R_FLAG, 8'h00);
      wr(R_CFG, 8'h01);
      tmr(3, 16'h1234, 16'h0000);
      rd(R_FLAG, 8'h02);
      tmr(3, 16'hFFFF, 16'h0000);
      rd(R_FLAG, 8'h42);
      wr(R_FLAG, 8'h00);
      tmr(0, 16'hFFFF, 16'h0000);
      rd(R_CORE, 8'h20);
      // Both pins with both edge selections; the wrong edge must not flag.
      for (int k = 0; k < 4; k++)
      begin
         pin(k[1], k[0]);
         wr(R_T0, k[0] ? (k[1] ? 8'h40 : 8'h80) : 8'h00);
         wr(R_CORE, 8'h00);
         pin(k[1], !k[0]);
         rd(R_CORE, 8'h00);
         pin(k[1], k[0]);
         rd(R_CORE, k[1] ? 8'h40 : 8'h10);
      end
      // Combined flag against enables and the global disable.
      pulse_cap(0);
      wr(R_EN, 8'h04);
      wr(R_CORE, 8'h08);
      rd(R_CORE, 8'h88);
      check(core_irq_req, 1'b1);
      wr(R_CPU, 8'h10);
      check(core_irq_req, 1'b0);
      rd(R_CORE, 8'h88);
      wr(R_CPU, 8'h00);
      wr(R_EN, 8'h00);
      rd(R_CORE, 8'h08);
      wr(R_FLAG, 8'h00);
      // Each pin source wakes the sleeping core only once enabled.
      wr(R_T0, 8'hC0);
      pin(0, 0);
      pin(1, 0);
      for (int s = 0; s < 2; s++)
      begin
         wr(R_CORE, 8'h00);
         @(posedge aclk);
         sleep_cmd <= 1'b1;
         @(posedge aclk);
         sleep_cmd <= 1'b0;
         pin(s[0], 1);
         check(wake_req, 1'b0);
         check(core_sleeping, 1'b1);
         wr(R_CORE, s[0] ? 8'h44 : 8'h11);
         repeat (2) @(posedge aclk);
         check(core_sleeping, 1'b0);
         pin(s[0], 0);
      end
      wr(R_CORE, 8'h00);
      // A port mismatch keeps re-flagging until the port is read.
      port_b_pins <= 8'h01;
      rd(R_FLAG, 8'h82);
      wr(R_FLAG, 8'h00);
      rd(R_FLAG, 8'h82);
      @(posedge aclk);
      read_cmd <= 1'b1;
      @(posedge aclk);
      read_cmd <= 1'b0;
      wr(R_FLAG, 8'h00);
      rd(R_FLAG, 8'h02);
      // A capture landing on the clearing write must survive it.
      pulse_cap(0);
      fork
         wr(R_FLAG, 8'h00);
         pulse_cap(0);
      join
      rd(R_FLAG, 8'h06);
      tally_and_finish();
   end
endmodule // test_interrupt_flag_logic
